/* File: core/hbwd_decode.sv */
// side-channel decoder: sync/enable/aux packets, audio stream, i2s output
// assumes a recovered 27-bit word with a strobe per pixel slot, AHB-Lite host
`include "hbwd_params.svh"

// Function
// - high-bandwidth mode takes a 27-bit word with 24-bit video, up to 104MHz
// - high-bandwidth packet decoding only when bus_width_select is left open; audio and side bits decoded in either mode
// - sync, enable and aux lines come from packets, not fixed bits
// - one packet slot sits before rise and after fall of sync/enable
// - aux packet replaces the slot before the sampled aux change
// - aux sampled always while enable low, only on sync edges otherwise
// - audio 8 to 192kHz, 8-32 bit I2S words or 64-256 bit TDM frames
// - audio arrives as one bit per word, synchronous with pixel clock
// - decoded audio words are written into a FIFO
// - output rate measured on internal oscillator, output driven as I2S
// - audio enabled after reset; disabled makes SD an aux control bit
// - spread spectrum does not change output audio rate
// - TDM, stereo I2S and nonstandard frames all accepted
// - data_rate_select clear doubles the pixel clock against set
// - bits 23:0 video or packet; 24 audio, 25 forward control, 26 parity
module hbwd_decode #(
	parameter int FIFO_DEPTH = 16,
	parameter int WORD_W     = 32
) (
	input  wire logic                  clk_in,
	input  wire logic                  rst_n_in,
	input  wire logic                  ce_in,
	input  wire logic                  link_clk_in,
	input  wire logic [26:0]           link_word_in,
	input  wire logic                  bus_width_open_in,
	input  wire logic                  hsel_in,
	input  wire logic [31:0]           haddr_in,
	input  wire logic [1:0]            htrans_in,
	input  wire logic                  hwrite_in,
	input  wire logic [2:0]            hsize_in,
	input  wire logic [31:0]           hwdata_in,
	input  wire logic                  hready_in,
	output logic [31:0]                hrdata_out,
	output logic                       hreadyout_out,
	output logic                       hresp_out,
	output logic                       horizontal_sync_out,
	output logic                       vertical_sync_out,
	output logic                       data_enable_out,
	output logic [3:0]                 aux_control_lines_out,
	output logic                       aux_sd_out,
	output logic                       fwd_ctrl_out,
	output logic                       parity_err_out,
	output logic                       i2s_sck_out,
	output logic                       i2s_ws_out,
	output logic                       i2s_sd_out
);
	localparam int AW = $clog2(FIFO_DEPTH);
	if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0 || WORD_W < 8 || WORD_W > 32) begin : g_bad_params
		$error("hbwd_decode: unsupported parameters");
	end

	// link clock: three flops, edge counts when stages 2 and 3 agree
	logic [2:0] lclk_sync_r;
	logic       lclk_level_r;
	logic       word_stb;
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			lclk_sync_r  <= 3'h0;
			lclk_level_r <= 1'b0;
		end else if (ce_in) begin
			lclk_sync_r <= {lclk_sync_r[1:0], link_clk_in};
			if (lclk_sync_r[1] == lclk_sync_r[2])
				lclk_level_r <= lclk_sync_r[2];
		end
	end
	assign word_stb = ce_in && (lclk_sync_r[1] == lclk_sync_r[2]) && lclk_sync_r[2] && !lclk_level_r;

	// word is stable across a link period, so capture it on the found edge
	logic [26:0] word_r;
	logic        word_v_r;
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			word_r   <= 27'h000_0000;
			word_v_r <= 1'b0;
		end else if (ce_in) begin
			word_v_r <= word_stb;
			if (word_stb)
				word_r <= link_word_in;
		end
	end

	// software control and status
	logic [31:0] ctrl_r;
	logic        hbw_mode;
	logic        audio_en;
	// bus width pin is a board level: three flops, level counts when stages 2 and 3 agree
	logic [2:0] bwo_sync_r;
	logic       hbw_mode_r;
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			bwo_sync_r <= 3'h0;
			hbw_mode_r <= 1'b0;
		end else if (ce_in) begin
			bwo_sync_r <= {bwo_sync_r[1:0], bus_width_open_in};
			if (bwo_sync_r[1] == bwo_sync_r[2])
				hbw_mode_r <= bwo_sync_r[2];
		end
	end
	assign hbw_mode = hbw_mode_r;
	assign audio_en = ctrl_r[0];

	function automatic logic is_pkt(input logic [23:0] v, input logic [3:0] kind);
		is_pkt = (v[23:16] == `HBWD_PKT_TAG) && (v[15:12] == kind);
	endfunction : is_pkt

	// packet decode: levels hold until the next packet
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			horizontal_sync_out   <= 1'b0;
			vertical_sync_out     <= 1'b0;
			data_enable_out       <= 1'b0;
			aux_control_lines_out <= 4'h0;
		end else if (ce_in && word_v_r && hbw_mode) begin
			if (is_pkt(word_r[`HBWD_VID_BITS-1:0], `HBWD_PKT_KIND_SYNC)) begin
				horizontal_sync_out <= word_r[0];
				vertical_sync_out   <= word_r[1];
				data_enable_out     <= word_r[2];
			end else if (is_pkt(word_r[`HBWD_VID_BITS-1:0], `HBWD_PKT_KIND_AUX)) begin
				aux_control_lines_out <= word_r[3:0];
			end
		end
	end

	// side bits of each word
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			aux_sd_out     <= 1'b0;
			fwd_ctrl_out   <= 1'b0;
			parity_err_out <= 1'b0;
		end else if (ce_in && word_v_r) begin
			fwd_ctrl_out   <= word_r[`HBWD_POS_FWD];
			parity_err_out <= ^word_r[`HBWD_WORD_BITS-1:0];
			if (!audio_en)
				aux_sd_out <= word_r[`HBWD_POS_AUDIO];
		end
	end

	// audio stream: start bit then WORD_W data bits, msb first
	hbwd_pkg::hbwd_aud_t   aud_st_r;
	logic [5:0]            aud_cnt_r;
	logic [WORD_W-1:0]     aud_sh_r;
	logic                  fifo_push;
	logic                  abit;
	assign abit = word_r[`HBWD_POS_AUDIO];
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			aud_st_r  <= hbwd_pkg::HBWD_A_IDLE;
			aud_cnt_r <= 6'h00;
			aud_sh_r  <= '0;
		end else if (ce_in && word_v_r && audio_en) begin
			case (aud_st_r)
				hbwd_pkg::HBWD_A_IDLE: begin
					if (abit)
						aud_st_r <= hbwd_pkg::HBWD_A_DATA;
					aud_cnt_r <= 6'h00;
				end
				hbwd_pkg::HBWD_A_DATA: begin
					aud_sh_r  <= {aud_sh_r[WORD_W-2:0], abit};
					aud_cnt_r <= aud_cnt_r + 6'h01;
					if (aud_cnt_r == 6'(WORD_W - 1))
						aud_st_r <= hbwd_pkg::HBWD_A_IDLE;
				end
				default: aud_st_r <= hbwd_pkg::HBWD_A_IDLE;
			endcase
		end
	end
	assign fifo_push = ce_in && word_v_r && audio_en && (aud_st_r == hbwd_pkg::HBWD_A_DATA)
		&& (aud_cnt_r == 6'(WORD_W - 1));

	// audio word fifo; overflow drops, underflow keeps the shifted-out register (last word's lsb, then zeros)
	logic [WORD_W-1:0] mem_r [FIFO_DEPTH];
	logic [AW:0]       wp_r;
	logic [AW:0]       rp_r;
	logic              full;
	logic              empty;
	logic              fifo_pop;
	assign full  = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
	assign empty = (wp_r == rp_r);
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			wp_r <= '0;
		end else if (fifo_push && !full) begin
			mem_r[wp_r[AW-1:0]] <= {aud_sh_r[WORD_W-2:0], abit};
			wp_r                <= wp_r + 1'b1;
		end
	end
	always_ff @(posedge clk_in) begin
		if (!rst_n_in)
			rp_r <= '0;
		else if (fifo_pop && !empty)
			rp_r <= rp_r + 1'b1;
	end

	// rate measurement: core clock cycles between words, averaged
	logic [15:0] gap_cnt_r;
	logic [15:0] rate_div_r;
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			gap_cnt_r  <= 16'h0000;
			rate_div_r <= `HBWD_OSC_DIV_RST;
		end else if (ce_in) begin
			if (fifo_push) begin
				gap_cnt_r <= 16'h0000;
				// smoothing filter; spread spectrum jitter averages out
				rate_div_r <= 16'((32'(rate_div_r) * 3 + 32'(gap_cnt_r / 16'(2 * WORD_W))) >> 2);
			end else if (gap_cnt_r != 16'hFFFF) begin
				gap_cnt_r <= gap_cnt_r + 16'h0001;
			end
		end
	end

	// i2s output: sck half period from measured rate, ws 50 percent
	logic [15:0]       div_cnt_r;
	logic [4:0]        bit_r;
	logic [WORD_W-1:0] out_sh_r;
	logic              sck_fall;
	assign sck_fall = ce_in && i2s_sck_out && (div_cnt_r == 16'h0000);
	assign fifo_pop = sck_fall && (bit_r == 5'(WORD_W - 1)) && i2s_ws_out;
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			div_cnt_r   <= 16'h0000;
			i2s_sck_out <= 1'b0;
		end else if (ce_in) begin
			if (div_cnt_r == 16'h0000) begin
				div_cnt_r   <= (rate_div_r > 16'h0001) ? rate_div_r - 16'h0001 : 16'h0000;
				i2s_sck_out <= !i2s_sck_out;
			end else begin
				div_cnt_r <= div_cnt_r - 16'h0001;
			end
		end
	end
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			bit_r      <= 5'h00;
			i2s_ws_out <= 1'b0;
			i2s_sd_out <= 1'b0;
			out_sh_r   <= '0;
		end else if (sck_fall) begin
			i2s_sd_out <= out_sh_r[WORD_W-1];
			if (bit_r == 5'(WORD_W - 1)) begin
				bit_r      <= 5'h00;
				i2s_ws_out <= !i2s_ws_out;
				out_sh_r   <= empty ? out_sh_r : mem_r[rp_r[AW-1:0]];
			end else begin
				bit_r    <= bit_r + 5'h01;
				out_sh_r <= {out_sh_r[WORD_W-2:0], 1'b0};
			end
		end
	end

	// AHB-Lite slave, zero wait states, always OKAY
	logic        dp_wr_r;
	logic        dp_rd_r;
	logic [31:0] dp_addr_r;
	logic        ap_take;
	assign ap_take = hsel_in && htrans_in[1] && hready_in;
	assign hreadyout_out = 1'b1;
	assign hresp_out     = 1'b0;
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			dp_wr_r   <= 1'b0;
			dp_rd_r   <= 1'b0;
			dp_addr_r <= 32'h0000_0000;
		end else if (ce_in) begin
			dp_wr_r   <= ap_take && hwrite_in;
			dp_rd_r   <= ap_take && !hwrite_in;
			dp_addr_r <= haddr_in;
		end
	end
	always_ff @(posedge clk_in) begin
		if (!rst_n_in)
			ctrl_r <= `HBWD_CTRL_RST;
		else if (ce_in && dp_wr_r && dp_addr_r == `HBWD_A_ADDR_CTRL)
			ctrl_r <= {30'h0000_0000, hwdata_in[1:0]};
	end
	always_comb begin
		if (dp_addr_r == `HBWD_A_ADDR_CTRL)
			hrdata_out = ctrl_r;
		else if (dp_addr_r == `HBWD_A_ADDR_STAT)
			hrdata_out = {26'h000_0000, full, empty, parity_err_out, hbw_mode, audio_en, data_enable_out};
		else if (dp_addr_r == `HBWD_A_ADDR_VIDEO)
			hrdata_out = {5'h00, word_r};
		else if (dp_addr_r == `HBWD_A_ADDR_RATE)
			hrdata_out = {16'h0000, rate_div_r};
		else
			hrdata_out = 32'h0000_0000;
		if (!dp_rd_r)
			hrdata_out = 32'h0000_0000;
	end

	// checks
	a_sync_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		!(word_v_r && ce_in) |=> $stable(horizontal_sync_out) && $stable(data_enable_out))
		else $error("sync level moved without a word");
	a_aux_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		!(word_v_r && ce_in) |=> $stable(aux_control_lines_out))
		else $error("aux lines moved without a word");
	a_mode_gate: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		!hbw_mode |=> $stable(vertical_sync_out))
		else $error("decode outside high-bandwidth mode");
	a_mode_follow: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		ce_in && bwo_sync_r[1] == bwo_sync_r[2] |=> hbw_mode == $past(bwo_sync_r[2]))
		else $error("mode does not follow settled pin");
	a_sync_decode: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		ce_in && word_v_r && hbw_mode && is_pkt(word_r[23:0], `HBWD_PKT_KIND_SYNC)
		|=> horizontal_sync_out == $past(word_r[0]) && vertical_sync_out == $past(word_r[1]))
		else $error("sync packet not decoded");
	a_aux_decode: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		ce_in && word_v_r && hbw_mode && is_pkt(word_r[23:0], `HBWD_PKT_KIND_AUX)
		|=> aux_control_lines_out == $past(word_r[3:0]))
		else $error("aux packet not decoded");
	a_fwd_bit: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		ce_in && word_v_r |=> fwd_ctrl_out == $past(word_r[25]))
		else $error("forward control bit wrong");
	a_parity_flag: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		ce_in && word_v_r |=> parity_err_out == $past(^word_r))
		else $error("parity flag wrong");
	a_fifo_write: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		fifo_push && !full |=> !empty)
		else $error("fifo write lost");
	a_fifo_drop: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		full |=> $stable(wp_r))
		else $error("full fifo overwritten");
	a_sd_aux: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		ce_in && word_v_r && !audio_en |=> aux_sd_out == $past(word_r[24]))
		else $error("sd not used as aux bit");
	a_audio_idle: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		!audio_en |=> $stable(aud_st_r) && $stable(wp_r))
		else $error("audio decoded while disabled");
	a_ws_toggle: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		$changed(i2s_ws_out) |-> $past(bit_r) == 5'(WORD_W - 1))
		else $error("ws edge off frame");
	c_sync_pkt: cover property (@(posedge clk_in) $rose(data_enable_out));
	c_aux_pkt: cover property (@(posedge clk_in) $changed(aux_control_lines_out));
	c_fifo_full: cover property (@(posedge clk_in) full);
	c_ws_edge: cover property (@(posedge clk_in) $rose(i2s_ws_out));
	c_audio_word: cover property (@(posedge clk_in) fifo_push);
endmodule : hbwd_decode

/* File: core/hbwd_params.svh */
// constants for the high-bandwidth side-channel decoder
// assumes a 100 MHz core clock and a link word of 27 bits
`ifndef HBWD_PARAMS_SVH
`define HBWD_PARAMS_SVH
`define HBWD_WORD_BITS      27
`define HBWD_VID_BITS       24
`define HBWD_POS_AUDIO      24
`define HBWD_POS_FWD        25
`define HBWD_POS_PARITY     26
`define HBWD_PKT_TAG        8'hA5
`define HBWD_PKT_KIND_SYNC  4'h1
`define HBWD_PKT_KIND_AUX   4'h2
`define HBWD_CLK_MHZ        100
`define HBWD_MAX_PCLK_MHZ   104
`define HBWD_OSC_DIV_RST    16'h0010
`define HBWD_A_ADDR_CTRL    32'h0000_0000
`define HBWD_A_ADDR_STAT    32'h0000_0004
`define HBWD_A_ADDR_VIDEO   32'h0000_0008
`define HBWD_A_ADDR_RATE    32'h0000_000C
`define HBWD_CTRL_RST       32'h0000_0003
`endif

/* File: core/hbwd_pkg.sv */
// types for the high-bandwidth side-channel decoder
// assumes nothing beyond the params header
package hbwd_pkg;
	typedef enum logic [1:0] {
		HBWD_A_IDLE = 2'b00,
		HBWD_A_SYNC = 2'b01,
		HBWD_A_DATA = 2'b10
	} hbwd_aud_t;
endpackage : hbwd_pkg

/* File: test/hbwd_ser_model.sv */
// serializer model: builds 27-bit link words and strobes the link clock
// assumes send is called just after a rising core clock edge
module hbwd_ser_model (
	input  wire logic        clk_in,
	output logic             link_clk_out,
	output logic [26:0]      link_word_out
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		link_clk_out = 1'b0;
		link_word_out = 27'h000_0000;
	end
	// one word per 160 ns link period, clock still between words
	task automatic send(input logic [23:0] vid, input logic aud, input logic fwd, input logic bad);
		logic [25:0] w;
		w = {fwd, aud, vid};
		@(posedge clk_in);
		link_word_out <= {(^w) ^ bad, w};
		repeat (4) @(posedge clk_in);
		link_clk_out <= 1'b1;
		repeat (8) @(posedge clk_in);
		link_clk_out <= 1'b0;
		repeat (3) @(posedge clk_in);
		link_word_out <= ~link_word_out; // invert after the fall, no stale value
	endtask : send
endmodule : hbwd_ser_model

/* File: test/test_hbwd_decode.sv */
// bench for the side-channel decoder: ahb register tasks, serializer model
// assumes 100 MHz core clock, link words every 160 ns
`include "hbwd_params.svh"
module test_hbwd_decode;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_in = 1'b0;
	logic        rst_n_in = 1'b0;
	logic        bwo = 1'b1;
	logic        hsel = 1'b0;
	logic        hwrite = 1'b0;
	logic [1:0]  htrans = 2'b00;
	logic [31:0] haddr = 32'h0000_0000;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [31:0] hrdata, rd;
	logic        hready, hresp, hs, vs, de, sd, fwd, perr, sck, ws, isd, lclk;
	logic [3:0]  aux;
	logic [26:0] lword;
	int          n_mismatch = 0;
	int          checks_done = 0;
	int          cyc = 0;
	int          n;
	always #5 clk_in = ~clk_in;
	hbwd_ser_model i_ser (.clk_in(clk_in), .link_clk_out(lclk), .link_word_out(lword));
	hbwd_decode i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(1'b1), .link_clk_in(lclk),
		.link_word_in(lword), .bus_width_open_in(bwo), .hsel_in(hsel), .haddr_in(haddr),
		.htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'b010), .hwdata_in(hwdata),
		.hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
		.horizontal_sync_out(hs), .vertical_sync_out(vs), .data_enable_out(de),
		.aux_control_lines_out(aux), .aux_sd_out(sd), .fwd_ctrl_out(fwd), .parity_err_out(perr),
		.i2s_sck_out(sck), .i2s_ws_out(ws), .i2s_sd_out(isd));
	task automatic test_done;
		$display("mismatches %0d checks %0d", n_mismatch, checks_done);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : test_done
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			test_done();
		end
	end
	task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t value %h expected %h", $time, got, exp);
		end
	endtask : cmp32
	task automatic cmp_lines(input logic [6:0] exp);
		checks_done++;
		if ({aux, de, vs, hs} !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t lines %b expected %b", $time, {aux, de, vs, hs}, exp);
		end
	endtask : cmp_lines
	task automatic cmp_bit(input logic got, input logic exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t flag %b expected %b", $time, got, exp);
		end
	endtask : cmp_bit
	// single ahb-lite transfer, entered just after a rising edge
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] r);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'b10;
		hwrite <= wr;
		do @(posedge clk_in); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge clk_in); while (hready !== 1'b1);
		r = hrdata;
		cmp_bit(hresp, 1'b0);
	endtask : bus
	// sck rise to next rise, in core clocks
	task automatic sck_period(output int p);
		p = 0;
		do @(posedge clk_in); while (sck !== 1'b0);
		do @(posedge clk_in); while (sck !== 1'b1);
		do begin @(posedge clk_in); p++; end while (sck !== 1'b0);
		do begin @(posedge clk_in); p++; end while (sck !== 1'b1);
	endtask : sck_period
	// ws change to next change, counted in sck rising edges
	task automatic ws_half(output int p);
		logic w0;
		logic k0;
		p = 0;
		w0 = ws;
		do @(posedge clk_in); while (ws === w0);
		w0 = ws;
		k0 = sck;
		do begin
			@(posedge clk_in);
			if (sck === 1'b1 && k0 === 1'b0)
				p++;
			k0 = sck;
		end while (ws === w0);
	endtask : ws_half
	initial begin
		repeat (5) @(posedge clk_in);
		rst_n_in <= 1'b1;
		@(posedge clk_in);
		bus(1'b0, `HBWD_A_ADDR_CTRL, 32'h0, rd);
		cmp32(rd, `HBWD_CTRL_RST);
		bus(1'b0, `HBWD_A_ADDR_STAT, 32'h0, rd);
		cmp32(rd, 32'h0000_0016);
		bus(1'b1, 32'h0000_0010, 32'hFFFF_FFFF, rd);
		bus(1'b0, 32'h0000_0010, 32'h0, rd);
		cmp32(rd, 32'h0000_0000);
		// each sync packet pattern, then an ordinary pixel that must not disturb it
		for (int i = 0; i < 8; i++) begin
			i_ser.send({8'hA5, 4'h1, 9'h000, i[2:0]}, 1'b0, 1'b0, 1'b0);
			cmp_lines({4'h0, i[2:0]});
			i_ser.send(24'h12_3456, 1'b0, 1'b0, 1'b0);
			cmp_lines({4'h0, i[2:0]});
		end
		for (int i = 0; i < 16; i++) begin
			i_ser.send({8'hA5, 4'h2, 8'h00, i[3:0]}, 1'b0, 1'b0, 1'b0);
			cmp_lines({i[3:0], 3'b111});
		end
		bwo <= 1'b0;
		i_ser.send({8'hA5, 4'h1, 12'h000}, 1'b0, 1'b0, 1'b0);
		cmp_lines(7'h7F);
		bwo <= 1'b1;
		i_ser.send(24'h00_00FF, 1'b0, 1'b1, 1'b0);
		cmp_bit(fwd, 1'b1);
		cmp_bit(perr, 1'b0);
		i_ser.send(24'h00_00FF, 1'b0, 1'b0, 1'b1);
		cmp_bit(perr, 1'b1);
		cmp_bit(fwd, 1'b0);
		bus(1'b0, `HBWD_A_ADDR_VIDEO, 32'h0, rd);
		cmp32(rd, 32'h0400_00FF);
		bus(1'b1, `HBWD_A_ADDR_CTRL, 32'h0, rd);
		bus(1'b0, `HBWD_A_ADDR_CTRL, 32'h0, rd);
		cmp32(rd, 32'h0000_0000);
		i_ser.send(24'h00_0000, 1'b1, 1'b0, 1'b0);
		cmp_bit(sd, 1'b1);
		i_ser.send(24'h00_0000, 1'b0, 1'b0, 1'b0);
		cmp_bit(sd, 1'b0);
		bus(1'b1, `HBWD_A_ADDR_CTRL, 32'h3, rd);
		bus(1'b0, `HBWD_A_ADDR_RATE, 32'h0, rd);
		cmp32(rd, {16'h0000, `HBWD_OSC_DIV_RST});
		sck_period(n);
		cmp32(32'(n), 32'(2 * `HBWD_OSC_DIV_RST));
		bus(1'b1, `HBWD_A_ADDR_RATE, 32'h0000_0008, rd);
		bus(1'b0, `HBWD_A_ADDR_RATE, 32'h0, rd);
		cmp32(rd, {16'h0000, `HBWD_OSC_DIV_RST});
		// all-ones stream: 33 link words per audio word, 16 core clocks per link word
		for (int i = 0; i < 16 * 33; i++)
			i_ser.send(24'h00_0000, 1'b1, 1'b0, 1'b0);
		bus(1'b0, `HBWD_A_ADDR_STAT, 32'h0, rd);
		cmp_bit(rd[4], 1'b0);
		sck_period(n);
		sck_period(n);
		cmp32(32'(n), 32'h0000_0010);
		ws_half(n);
		cmp32(32'(n), 32'h0000_0020);
		cmp_bit(isd, 1'b1);
		test_done();
	end
endmodule : test_hbwd_decode
